// *** verilog/rbc_ctrl.sv ***
/*
  RAM self-test control: the self-test control register, the test sequencer
  and the arbitration of the internal RAM between host and sequencer.
  Assumes register and RAM host strobes are synchronous to clk_in; the test pin is not.
*/
`timescale 1ns/1ps
// Summary of operation
// - Reset or soft reset clears every control bit to zero.
// - Unlock bit 15 lets host writes reach every RAM bit, protected ones too.
// - Force-fail bit 14 makes the test report failure whatever RAM holds.
// - Selector bits 13:11 pick the test; codes 000 and 111 run nothing.
// - Code 001 runs the full multi-pattern march test.
// - Code 010 writes zero to every address up to 0x1FFF.
// - Code 011 reads every address and flags any word not zero.
// - Code 100 writes all-ones to every address up to 0x1FFF.
// - Code 101 reads every address and flags any word not all-ones.
// - Code 110 runs only the ones-fill and descending march half.
// - Bit 10 starts the test; bits 9 and 8 report pass and fail.
// - The register works only while the test pin is high.
// - Every test except the check codes 011 and 101 overwrites the previous RAM contents.
module rbc_ctrl #(
  parameter int ADDR_W = 13
) (
  // Clock and resets
  input  wire logic                           clk_in,
  input  wire logic                           arst_n_in,
  input  wire logic                           soft_reset_in,
  // Test mode pin
  input  wire logic                           test_mode_in,
  // Host register port
  input  wire logic                           reg_wr_in,
  input  wire logic                           reg_rd_in,
  input  wire logic [rbc_pkg::REG_ADDR_W-1:0] reg_addr_in,
  input  wire logic [15:0]                    reg_wdata_in,
  output logic      [15:0]                    reg_rdata_out,
  // Host RAM port
  input  wire logic                           ram_wr_in,
  input  wire logic [ADDR_W-1:0]              ram_addr_in,
  input  wire logic [15:0]                    ram_wdata_in,
  input  wire logic [15:0]                    ram_prot_mask_in,
  output logic      [15:0]                    ram_rdata_out,
  output logic                                bist_busy_out
);
  import rbc_pkg::*;

  initial begin
    if (ADDR_W != 13) begin
      $error("rbc_ctrl supports only a 13-bit RAM address");
    end
  end

  // ------------------------------------------------------------
  // Types, state and helpers
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_FILL   = 3'b001,
    ST_VERIFY = 3'b010,
    ST_MARCH  = 3'b011,
    ST_DONE   = 3'b100
  } rbc_state_t;

  function automatic logic [15:0] march_word(input logic [3:0] idx, input logic [15:0] base);
    case (idx)
      4'h1:    march_word = 16'h5555;
      4'h2:    march_word = 16'hAAAA;
      4'h3:    march_word = 16'h3333;
      4'h4:    march_word = 16'hCCCC;
      4'h5:    march_word = 16'h0F0F;
      4'h6:    march_word = 16'hF0F0;
      4'h7:    march_word = 16'h00FF;
      4'h8:    march_word = 16'hFF00;
      default: march_word = base;
    endcase
  endfunction

  rbc_state_t   state_r,  state_nxt;
  rbc_ctrl_t    ctrl_r,   ctrl_nxt;
  logic [12:0]  addr_r,   addr_nxt;
  logic [1:0]   phase_r,  phase_nxt;
  logic [3:0]   pidx_r,   pidx_nxt;
  logic [1:0]   sub_r,    sub_nxt;
  logic         single_r, single_nxt;
  logic         err_r,    err_nxt;
  logic         pass_r,   pass_nxt;
  logic         fail_r,   fail_nxt;
  logic         tm_meta_r;
  logic         tm_sync_r;
  logic [15:0]  rdata_r;
  logic [15:0]  ram_q;
  rbc_ram_req_t ram_req;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire         reg_hit     = tm_sync_r && (reg_addr_in == SELF_TEST_ADDR);
  wire         reg_wr_hit  = reg_hit && reg_wr_in;
  wire [2:0]   wr_sel      = reg_wdata_in[SEL_HI:SEL_LO];
  wire         sel_runs    = (wr_sel != SEL_IDLE_LO) && (wr_sel != SEL_IDLE_HI);
  wire         start       = reg_wr_hit && reg_wdata_in[BIT_GO] && sel_runs &&
                             (state_r == ST_IDLE);
  wire         engine_on   = (state_r != ST_IDLE) && (state_r != ST_DONE);
  wire [15:0]  base_word   = phase_r[1] ? WORD_ONES : WORD_ZERO;
  wire [15:0]  expect_word = march_word(pidx_r, base_word);
  wire         march_up    = (phase_r == 2'd1);
  wire [12:0]  addr_end    = march_up ? RAM_LAST : RAM_FIRST;
  wire [12:0]  addr_step   = march_up ? 13'(addr_r + 13'h0001) : 13'(addr_r - 13'h0001);
  wire         check_now   = ((state_r == ST_VERIFY) || (state_r == ST_MARCH)) &&
                             (sub_r == 2'd2);
  wire         mismatch    = check_now && (ram_q != expect_word);
  wire [15:0]  host_bwe    = ctrl_r.unlock ? WORD_ONES : ~ram_prot_mask_in;

  // RAM arbitration: the sequencer owns the array while a test runs.
  always_comb begin
    ram_req.we    = 1'b0;
    ram_req.bwe   = WORD_ONES;
    ram_req.addr  = addr_r;
    ram_req.wdata = WORD_ZERO;
    if (engine_on) begin
      ram_req.we    = (state_r == ST_FILL) || ((state_r == ST_MARCH) && (sub_r == 2'd0));
      ram_req.wdata = (state_r == ST_FILL) ? base_word : expect_word;
    end else begin
      ram_req.we    = ram_wr_in;
      ram_req.bwe   = host_bwe;
      ram_req.addr  = ram_addr_in;
      ram_req.wdata = ram_wdata_in;
    end
  end

  rbc_ram #(.ADDR_W(ADDR_W), .DATA_W(16)) u_ram (
    .clk_in (clk_in),
    .req_in (ram_req),
    .q_out  (ram_q)
  );

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt  = state_r;
    ctrl_nxt   = ctrl_r;
    addr_nxt   = addr_r;
    phase_nxt  = phase_r;
    pidx_nxt   = pidx_r;
    sub_nxt    = sub_r;
    single_nxt = single_r;
    err_nxt    = err_r | mismatch;
    pass_nxt   = pass_r;
    fail_nxt   = fail_r;
    if (reg_wr_hit) begin
      ctrl_nxt.unlock     = reg_wdata_in[BIT_UNLOCK];
      ctrl_nxt.force_fail = reg_wdata_in[BIT_FORCE];
      if (state_r == ST_IDLE) begin
        ctrl_nxt.sel = rbc_sel_t'(wr_sel);
      end
    end
    case (state_r)
      ST_IDLE: begin
        if (start) begin
          ctrl_nxt.go = 1'b1;
          pass_nxt    = 1'b0;
          fail_nxt    = 1'b0;
          err_nxt     = 1'b0;
          addr_nxt    = RAM_FIRST;
          pidx_nxt    = 4'h0;
          sub_nxt     = 2'd1;
          single_nxt  = (wr_sel != SEL_PATTERN) && (wr_sel != SEL_INCDEC);
          case (wr_sel)
            SEL_PATTERN: begin state_nxt = ST_FILL;   phase_nxt = 2'd0; end
            SEL_FILL0:   begin state_nxt = ST_FILL;   phase_nxt = 2'd0; end
            SEL_CHECK0:  begin state_nxt = ST_VERIFY; phase_nxt = 2'd0; end
            SEL_FILL1:   begin state_nxt = ST_FILL;   phase_nxt = 2'd2; end
            SEL_CHECK1:  begin state_nxt = ST_VERIFY; phase_nxt = 2'd2; end
            SEL_INCDEC:  begin state_nxt = ST_FILL;   phase_nxt = 2'd2; end
            default:     begin state_nxt = ST_IDLE;   phase_nxt = 2'd0; end
          endcase
        end
      end
      ST_FILL: begin
        addr_nxt = 13'(addr_r + 13'h0001);
        if (addr_r == RAM_LAST) begin
          if (single_r) begin
            state_nxt = ST_DONE;
          end else begin
            // Zero fill leads to the ascending march, ones fill to the descending one.
            state_nxt = ST_MARCH;
            phase_nxt = 2'(phase_r + 2'd1);
            addr_nxt  = phase_r[1] ? RAM_LAST : RAM_FIRST;
            pidx_nxt  = 4'h0;
            sub_nxt   = 2'd1;
          end
        end
      end
      ST_VERIFY: begin
        sub_nxt = (sub_r == 2'd1) ? 2'd2 : 2'd1;
        if (sub_r == 2'd2) begin
          addr_nxt = 13'(addr_r + 13'h0001);
          if (addr_r == RAM_LAST) begin
            state_nxt = ST_DONE;
          end
        end
      end
      ST_MARCH: begin
        if (sub_r == 2'd2) begin
          pidx_nxt = 4'(pidx_r + 4'h1);
          sub_nxt  = 2'd0;
        end else if (sub_r == 2'd1) begin
          sub_nxt = 2'd2;
        end else if (pidx_r == MARCH_LAST) begin
          pidx_nxt = 4'h0;
          sub_nxt  = 2'd1;
          addr_nxt = addr_step;
          if (addr_r == addr_end) begin
            if (phase_r == 2'd1) begin
              state_nxt = ST_FILL;
              phase_nxt = 2'd2;
              addr_nxt  = RAM_FIRST;
            end else begin
              state_nxt = ST_DONE;
            end
          end
        end else begin
          sub_nxt = 2'd1;
        end
      end
      ST_DONE: begin
        state_nxt   = ST_IDLE;
        ctrl_nxt.go = 1'b0;
        pass_nxt    = !err_r && !ctrl_r.force_fail;
        fail_nxt    = err_r || ctrl_r.force_fail;
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (soft_reset_in) begin
      state_nxt = ST_IDLE;
      ctrl_nxt  = rbc_ctrl_t'(6'h00);
      pass_nxt  = 1'b0;
      fail_nxt  = 1'b0;
      err_nxt   = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r  <= ST_IDLE;
      ctrl_r   <= rbc_ctrl_t'(6'h00);
      addr_r   <= RAM_FIRST;
      phase_r  <= 2'd0;
      pidx_r   <= 4'h0;
      sub_r    <= 2'd0;
      single_r <= 1'b0;
      err_r    <= 1'b0;
      pass_r   <= 1'b0;
      fail_r   <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      ctrl_r   <= ctrl_nxt;
      addr_r   <= addr_nxt;
      phase_r  <= phase_nxt;
      pidx_r   <= pidx_nxt;
      sub_r    <= sub_nxt;
      single_r <= single_nxt;
      err_r    <= err_nxt;
      pass_r   <= pass_nxt;
      fail_r   <= fail_nxt;
    end
  end

  // The test pin is asynchronous to clk_in.
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tm_meta_r <= 1'b0;
      tm_sync_r <= 1'b0;
      rdata_r   <= CTRL_RESET;
    end else begin
      tm_meta_r <= test_mode_in;
      tm_sync_r <= tm_meta_r;
      if (reg_rd_in) begin
        rdata_r <= reg_hit ? {ctrl_r, pass_r, fail_r, 8'h00} : CTRL_RESET;
      end
    end
  end

  assign reg_rdata_out = rdata_r;
  assign ram_rdata_out = ram_q;
  assign bist_busy_out = engine_on;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!arst_n_in);

  a_soft_reset_clear: assert property (soft_reset_in |=> (ctrl_r == 6'h00) && !pass_r && !fail_r)
    else $error("control bits not cleared by soft reset");
  a_unlock_full_write: assert property (!engine_on && ram_wr_in && ctrl_r.unlock |-> ram_req.bwe == WORD_ONES)
    else $error("unlocked host write masked");
  a_force_fail_wins: assert property (state_r == ST_DONE && ctrl_r.force_fail && !soft_reset_in |=> fail_r && !pass_r)
    else $error("forced failure not reported");
  a_idle_code_stays: assert property (reg_wr_hit && reg_wdata_in[BIT_GO] && !sel_runs && state_r == ST_IDLE |=> state_r == ST_IDLE && !ctrl_r.go)
    else $error("idle selector code started a test");
  a_fill_zero_word: assert property (state_r == ST_FILL && phase_r == 2'd0 |-> ram_req.we && ram_req.wdata == WORD_ZERO)
    else $error("zero fill wrote wrong word");
  a_fill_ones_word: assert property (state_r == ST_FILL && phase_r == 2'd2 |-> ram_req.we && ram_req.wdata == WORD_ONES)
    else $error("ones fill wrote wrong word");
  a_verify_catch: assert property (mismatch && !soft_reset_in |=> err_r)
    else $error("read mismatch not recorded");
  a_start_clears: assert property (start && !soft_reset_in |=> ctrl_r.go && !pass_r && !fail_r ##1 engine_on)
    else $error("start did not launch test");
  // Only while idle: a test that ends with the pin low still clears go on its own.
  a_pin_low_gate: assert property (!tm_sync_r && reg_wr_in && !soft_reset_in && state_r == ST_IDLE |=> $stable(ctrl_r))
    else $error("register written with test pin low");
  a_result_holds: assert property (state_r == ST_IDLE && !start && !soft_reset_in |=> $stable(pass_r) && $stable(fail_r))
    else $error("result changed while idle");

  c_pattern_run: cover property (start && wr_sel == SEL_PATTERN);
  c_pass_seen:   cover property (state_r == ST_DONE ##1 pass_r);
  c_fail_seen:   cover property (state_r == ST_DONE ##1 fail_r);
  c_march_down:  cover property (state_r == ST_MARCH && phase_r == 2'd3);

endmodule

// *** verilog/rbc_pkg.sv ***
/*
  Shared constants and types for the RAM self-test control block.
  Assumes a 10 MHz core clock and one 16-bit control register on the host register port.
*/
package rbc_pkg;

  // ------------------------------------------------------------
  // Register map and field positions
  // ------------------------------------------------------------
  localparam int             REG_ADDR_W     = 8;
  localparam logic [7:0]     SELF_TEST_ADDR = 8'h28;
  localparam int             BIT_UNLOCK     = 15;
  localparam int             BIT_FORCE      = 14;
  localparam int             SEL_HI         = 13;
  localparam int             SEL_LO         = 11;
  localparam int             BIT_GO         = 10;
  localparam int             BIT_PASS       = 9;
  localparam int             BIT_FAIL       = 8;
  localparam logic [15:0]    CTRL_RESET     = 16'h0000;

  // ------------------------------------------------------------
  // Data words and address range
  // ------------------------------------------------------------
  localparam logic [15:0]    WORD_ZERO      = 16'h0000;
  localparam logic [15:0]    WORD_ONES      = 16'hFFFF;
  localparam logic [12:0]    RAM_FIRST      = 13'h0000;
  localparam logic [12:0]    RAM_LAST       = 13'h1FFF;
  localparam logic [3:0]     MARCH_LAST     = 4'h9;
  localparam logic [3:0]     MARCH_PAT_LAST = 4'h8;

  // ------------------------------------------------------------
  // Nominal test times and their cycle counts
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS  = 100;
  localparam int T_PATTERN_NS   = 14_420_000;
  localparam int T_FILL_NS      = 170_000;
  localparam int T_VERIFY_NS    = 500_000;
  localparam int T_INCDEC_NS    = 1_320_000;
  localparam int T_PATTERN_CYC  = T_PATTERN_NS / CLK_PERIOD_NS;
  localparam int T_FILL_CYC     = T_FILL_NS / CLK_PERIOD_NS;
  localparam int T_VERIFY_CYC   = T_VERIFY_NS / CLK_PERIOD_NS;
  localparam int T_INCDEC_CYC   = T_INCDEC_NS / CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    SEL_IDLE_LO = 3'b000,
    SEL_PATTERN = 3'b001,
    SEL_FILL0   = 3'b010,
    SEL_CHECK0  = 3'b011,
    SEL_FILL1   = 3'b100,
    SEL_CHECK1  = 3'b101,
    SEL_INCDEC  = 3'b110,
    SEL_IDLE_HI = 3'b111
  } rbc_sel_t;

  typedef struct packed {
    logic     unlock;
    logic     force_fail;
    rbc_sel_t sel;
    logic     go;
  } rbc_ctrl_t;

  typedef struct packed {
    logic        we;
    logic [15:0] bwe;
    logic [12:0] addr;
    logic [15:0] wdata;
  } rbc_ram_req_t;

endpackage

// *** verilog/rbc_ram.sv ***
/*
  Single-port 8K x 16 RAM with per-bit write enables and a registered read.
  Assumes one clock; reads return data one edge after the address is presented.
*/
`timescale 1ns/1ps
module rbc_ram #(
  parameter int ADDR_W = 13,
  parameter int DATA_W = 16
) (
  // Clock
  input  wire logic              clk_in,
  // Access
  input  wire rbc_pkg::rbc_ram_req_t req_in,
  // Read data
  output logic [DATA_W-1:0]      q_out
);
  import rbc_pkg::*;

  initial begin
    if (ADDR_W != 13 || DATA_W != 16) begin
      $error("rbc_ram supports only 13 address and 16 data bits");
    end
  end

  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

  // No reset: array contents are undefined until a test or host write fills them.
  always_ff @(posedge clk_in) begin
    if (req_in.we) begin
      mem[req_in.addr] <= (mem[req_in.addr] & ~req_in.bwe) | (req_in.wdata & req_in.bwe);
    end
    q_out <= mem[req_in.addr];
  end

endmodule

// *** dv/tb_top.sv ***
/*
  Self-checking bench for the RAM self-test control block.
  Assumes rbc_pkg is compiled first; no partner model, the bench drives every port itself.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, e, g); end end

module tb_top;
  import rbc_pkg::*;

  // ------------------------------------------------------------
  // Stimulus and observed signals
  // ------------------------------------------------------------
  logic        clk_in           = 1'b0;
  logic        arst_n_in        = 1'b0;
  logic        soft_reset_in    = 1'b0;
  logic        test_mode_in     = 1'b1;
  logic        reg_wr_in        = 1'b0;
  logic        reg_rd_in        = 1'b0;
  logic [7:0]  reg_addr_in      = 8'h00;
  logic [15:0] reg_wdata_in     = 16'h0000;
  logic [15:0] reg_rdata_out;
  logic        ram_wr_in        = 1'b0;
  logic [12:0] ram_addr_in      = 13'h0000;
  logic [15:0] ram_wdata_in     = 16'h0000;
  logic [15:0] ram_prot_mask_in = 16'h0000;
  logic [15:0] ram_rdata_out;
  logic        bist_busy_out;
  logic        ram_chk          = 1'b0;
  logic        rd_pend          = 1'b0;
  logic        ram_pend         = 1'b0;
  logic [15:0] e_reg;
  logic [15:0] e_ram;
  logic [15:0] reg_q[$];
  logic [15:0] ram_q[$];
  int          n_errors         = 0;
  int          checks           = 0;
  int          seed             = 92;

  rbc_ctrl dut_u (
    .clk_in          (clk_in),
    .arst_n_in       (arst_n_in),
    .soft_reset_in   (soft_reset_in),
    .test_mode_in    (test_mode_in),
    .reg_wr_in       (reg_wr_in),
    .reg_rd_in       (reg_rd_in),
    .reg_addr_in     (reg_addr_in),
    .reg_wdata_in    (reg_wdata_in),
    .reg_rdata_out   (reg_rdata_out),
    .ram_wr_in       (ram_wr_in),
    .ram_addr_in     (ram_addr_in),
    .ram_wdata_in    (ram_wdata_in),
    .ram_prot_mask_in(ram_prot_mask_in),
    .ram_rdata_out   (ram_rdata_out),
    .bist_busy_out   (bist_busy_out)
  );

  always #50 clk_in = ~clk_in;

  // ------------------------------------------------------------
  // Result watcher: read data is due one edge after its strobe
  // ------------------------------------------------------------
  always @(posedge clk_in) begin
    if (rd_pend) begin
      e_reg = reg_q.pop_front();
      `CHK("reg_rdata", e_reg, reg_rdata_out)
    end
    if (ram_pend) begin
      e_ram = ram_q.pop_front();
      `CHK("ram_rdata", e_ram, ram_rdata_out)
    end
    rd_pend  <= reg_rd_in;
    ram_pend <= ram_chk;
  end

  // ------------------------------------------------------------
  // Bus tasks; each leaves at least one idle edge so strobes never merge
  // ------------------------------------------------------------
  task automatic reg_write(input logic [7:0] a, input logic [15:0] d);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clk_in);
    reg_wr_in    <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic reg_read(input logic [7:0] a, input logic [15:0] e);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    reg_q.push_back(e);
    @(posedge clk_in);
    reg_rd_in   <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic ram_write(input logic [12:0] a, input logic [15:0] d, input logic [15:0] m);
    ram_addr_in      <= a;
    ram_wdata_in     <= d;
    ram_prot_mask_in <= m;
    ram_wr_in        <= 1'b1;
    @(posedge clk_in);
    ram_wr_in        <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic ram_read(input logic [12:0] a, input logic [15:0] e);
    ram_addr_in <= a;
    ram_chk     <= 1'b1;
    ram_q.push_back(e);
    @(posedge clk_in);
    ram_chk     <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic pulse_soft();
    soft_reset_in <= 1'b1;
    @(posedge clk_in);
    soft_reset_in <= 1'b0;
    repeat (2) @(posedge clk_in);
  endtask

  function automatic logic [15:0] ctl(input logic f, input logic [2:0] s, input logic p,
                                      input logic x);
    return {1'b0, f, s, 1'b0, p, x, 8'h00};
  endfunction

  // Starts a test, waits a bounded time for it to finish, then reads the verdict twice.
  task automatic run_test(input logic [2:0] s, input logic f, input logic p, input logic x);
    int n;
    reg_write(SELF_TEST_ADDR, {1'b0, f, s, 1'b1, 10'h000});
    `CHK("busy_start", 1'b1, bist_busy_out)
    n = 0;
    while (bist_busy_out === 1'b1 && n < 20000) begin
      @(posedge clk_in);
      n++;
    end
    `CHK("busy_end", 1'b0, bist_busy_out)
    repeat (2) @(posedge clk_in);
    reg_read(SELF_TEST_ADDR, ctl(f, s, p, x));
    reg_read(SELF_TEST_ADDR, ctl(f, s, p, x));
  endtask

  task automatic report_and_stop();
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    n_errors++;
    report_and_stop();
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin : main_seq
    logic [12:0] a;
    logic [15:0] d0;
    logic [15:0] d1;
    logic [15:0] d2;
    logic [15:0] m;
    logic [2:0]  longs[2];
    a  = $random(seed);
    d0 = $random(seed);
    d1 = $random(seed);
    d2 = $random(seed);
    m  = $random(seed);
    longs[0] = SEL_PATTERN;
    longs[1] = SEL_INCDEC;
    repeat (6) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    reg_read(SELF_TEST_ADDR, CTRL_RESET);
    // Reserved bits 7:0 must not take written ones.
    reg_write(SELF_TEST_ADDR, 16'hC8FF);
    reg_write(8'h29, 16'hFFFF);
    reg_read(8'h29, 16'h0000);
    reg_read(SELF_TEST_ADDR, 16'hC800);
    pulse_soft();
    reg_read(SELF_TEST_ADDR, CTRL_RESET);
    // With the pin low the address is dead but old contents survive.
    reg_write(SELF_TEST_ADDR, 16'h9000);
    test_mode_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    reg_write(SELF_TEST_ADDR, 16'h4800);
    reg_read(SELF_TEST_ADDR, 16'h0000);
    test_mode_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    reg_read(SELF_TEST_ADDR, 16'h9000);
    reg_write(SELF_TEST_ADDR, 16'h0400);
    reg_read(SELF_TEST_ADDR, 16'h0000);
    reg_write(SELF_TEST_ADDR, 16'h3C00);
    `CHK("busy_idle", 1'b0, bist_busy_out)
    reg_read(SELF_TEST_ADDR, 16'h3800);
    // Protected bits hold unless unlocked.
    ram_write(a, d0, 16'h0000);
    ram_write(a, d1, m);
    ram_read(a, (d1 & ~m) | (d0 & m));
    reg_write(SELF_TEST_ADDR, 16'h8000);
    ram_write(a, d2, m);
    ram_read(a, d2);
    reg_write(SELF_TEST_ADDR, 16'h0000);
    ram_write(a, d0, m);
    ram_read(a, (d0 & ~m) | (d2 & m));
    run_test(SEL_FILL0, 1'b0, 1'b1, 1'b0);
    ram_read(a, WORD_ZERO);
    ram_read(RAM_FIRST, WORD_ZERO);
    ram_read(RAM_LAST, WORD_ZERO);
    run_test(SEL_CHECK0, 1'b0, 1'b1, 1'b0);
    ram_write(a ^ 13'h0A5A, d1 | 16'h0001, 16'h0000);
    run_test(SEL_CHECK0, 1'b0, 1'b0, 1'b1);
    run_test(SEL_FILL1, 1'b0, 1'b1, 1'b0);
    ram_read(RAM_FIRST, WORD_ONES);
    ram_read(RAM_LAST, WORD_ONES);
    // A host write during a test is refused, so the ones check still passes.
    fork
      run_test(SEL_CHECK1, 1'b0, 1'b1, 1'b0);
      begin
        repeat (40) @(posedge clk_in);
        ram_write(a, WORD_ZERO, 16'h0000);
      end
    join
    ram_read(a, WORD_ONES);
    run_test(SEL_FILL0, 1'b1, 1'b0, 1'b1);
    ram_read(a, WORD_ZERO);
    // The long tests are only started and then cut short by a soft reset.
    foreach (longs[i]) begin
      reg_write(SELF_TEST_ADDR, {2'b11, longs[i], 1'b1, 10'h000});
      `CHK("busy_long", 1'b1, bist_busy_out)
      repeat (50) @(posedge clk_in);
      pulse_soft();
      `CHK("busy_abort", 1'b0, bist_busy_out)
      reg_read(SELF_TEST_ADDR, CTRL_RESET);
    end
    repeat (3) @(posedge clk_in);
    report_and_stop();
  end

endmodule
